// ==== src/spcs_defines.svh ====
// Offsets, bit positions and reset values of the serial port control block
`ifndef SPCS_DEFINES_SVH
`define SPCS_DEFINES_SVH

// Register byte addresses
`define SPCS_OFS_RCV_CTRL 8'h18
`define SPCS_OFS_XMT_CTRL 8'h98
`define SPCS_OFS_RCV_DATA 8'h1C
`define SPCS_OFS_INT_STAT 8'h20
`define SPCS_OFS_INT_MASK 8'h24

// Transmit status and control bits
`define SPCS_TX_CLOCK_SOURCE 7
`define SPCS_TX_WIDTH 6
`define SPCS_TX_ENABLE 5
`define SPCS_TX_LINK_MODE 4
`define SPCS_TX_SPEED 2
`define SPCS_TX_SHIFTER_EMPTY 1
`define SPCS_TX_NINTH 0
`define SPCS_TX_WRITE_MASK 8'hF5
`define SPCS_TX_RESET 8'h00

// Receive status and control bits
`define SPCS_RX_PORT_ENABLE 7
`define SPCS_RX_WIDTH 6
`define SPCS_RX_SINGLE 5
`define SPCS_RX_CONTINUOUS 4
`define SPCS_RX_ADDR_DETECT 3
`define SPCS_RX_FRAMING 2
`define SPCS_RX_OVERRUN 1
`define SPCS_RX_NINTH 0
`define SPCS_RX_WRITE_MASK 8'hF8
`define SPCS_RX_RESET 8'h00

// Interrupt status and mask bits
`define SPCS_INT_W 4
`define SPCS_INT_RX_WORD 0
`define SPCS_INT_FRAMING 1
`define SPCS_INT_OVERRUN 2
`define SPCS_INT_TX_EMPTY 3
`define SPCS_INT_RESET 4'h0

// Pin indices of the synchroniser bank
`define SPCS_PIN_CLOCK 0
`define SPCS_PIN_DATA 1
`define SPCS_PIN_COUNT 2

`endif

// ==== src/spcs_pkg.sv ====
// Types shared by the serial port control block and its data path
package spcs_pkg;

    // Word delivered by the receive shift register
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic ninth;
        logic framing_error;
    } spcs_rx_word_type;

    // Mode and enable controls handed to baud generator and data paths
    typedef struct packed {
        logic port_on;
        logic sync_mode;
        logic master;
        logic speed_high;
        logic tx_enable;
        logic tx_nine;
        logic tx_ninth_bit;
        logic rx_enable;
        logic rx_single;
        logic rx_nine;
    } spcs_ctrl_type;

    // One two-way pin as seen by the data path
    typedef struct packed {
        logic out;
        logic oe;
    } spcs_drive_type;

endpackage

// ==== src/spcs_top.sv ====
// Serial port control and status registers with Wishbone slave and pin gating
//
// Chosen here: the Wishbone slave port.
`include "spcs_defines.svh"

module spcs_top
    import spcs_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [DATA_W/8-1:0] wb_sel_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq,
    // Port logic direction bits for the two pins
    input wire logic [1:0] port_direction_bits,
    // Data path side
    input wire spcs_rx_word_type rx_word,
    input wire logic tx_shifter_empty,
    input wire spcs_drive_type dp_clock_drive,
    input wire spcs_drive_type dp_data_drive,
    output spcs_ctrl_type ctrl,
    output logic clock_pin_sync,
    output logic data_pin_sync,
    output logic [7:0] receive_data_register,
    output logic pins_owned,
    // Transmit clock pin
    input wire logic transmit_clock_pin_in,
    output logic transmit_clock_pin_out,
    output logic transmit_clock_pin_oe,
    // Receive data pin
    input wire logic receive_data_pin_in,
    output logic receive_data_pin_out,
    output logic receive_data_pin_oe
);

    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Register state
    logic [7:0] xmt_ctrl;
    logic [7:0] rcv_ctrl;
    logic shifter_empty;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic receive_ninth_bit;
    logic buffer_full;
    logic [`SPCS_INT_W-1:0] int_status;
    logic [`SPCS_INT_W-1:0] int_mask;
    logic shifter_empty_prev;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire bus_rd = bus_req & ~wb_we_i;
    wire sel_xmt = (wb_adr_i == `SPCS_OFS_XMT_CTRL);
    wire sel_rcv = (wb_adr_i == `SPCS_OFS_RCV_CTRL);
    wire sel_rdata = (wb_adr_i == `SPCS_OFS_RCV_DATA);
    wire sel_stat = (wb_adr_i == `SPCS_OFS_INT_STAT);
    wire sel_mask = (wb_adr_i == `SPCS_OFS_INT_MASK);
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire wr_xmt = bus_wr & sel_xmt;
    wire wr_rcv = bus_wr & sel_rcv;
    wire rd_rdata = bus_rd & sel_rdata;

    // Control fields
    wire link_sync = xmt_ctrl[`SPCS_TX_LINK_MODE];
    wire clk_master = xmt_ctrl[`SPCS_TX_CLOCK_SOURCE];
    wire port_en = rcv_ctrl[`SPCS_RX_PORT_ENABLE];
    wire rx_nine = rcv_ctrl[`SPCS_RX_WIDTH];
    wire single_rx = rcv_ctrl[`SPCS_RX_SINGLE];
    wire cont_rx = rcv_ctrl[`SPCS_RX_CONTINUOUS];
    wire addr_det = rcv_ctrl[`SPCS_RX_ADDR_DETECT];

    // Mode decode
    wire is_master = link_sync & clk_master;
    wire single_mode = is_master & single_rx & ~cont_rx;
    wire rx_active = port_en & (cont_rx | single_mode);
    wire tx_blocked = link_sync & (single_rx | cont_rx);
    wire tx_active = port_en & xmt_ctrl[`SPCS_TX_ENABLE] & ~tx_blocked;
    wire filter_on = ~link_sync & rx_nine & addr_det;
    wire word_in = rx_word.valid & rx_active;
    wire accept = ~filter_on | rx_word.ninth;
    wire load_word = word_in & accept & ~buffer_full;
    wire overrun_evt = word_in & accept & buffer_full;
    wire single_done = word_in & single_mode;
    wire owned_now = port_en & (&port_direction_bits);

    // Next control value
    spcs_ctrl_type next_ctrl;
    assign next_ctrl.port_on = port_en;
    assign next_ctrl.sync_mode = link_sync;
    assign next_ctrl.master = is_master;
    assign next_ctrl.speed_high = ~link_sync & xmt_ctrl[`SPCS_TX_SPEED];
    assign next_ctrl.tx_enable = tx_active;
    assign next_ctrl.tx_nine = xmt_ctrl[`SPCS_TX_WIDTH];
    assign next_ctrl.tx_ninth_bit = xmt_ctrl[`SPCS_TX_NINTH];
    assign next_ctrl.rx_enable = rx_active;
    assign next_ctrl.rx_single = single_mode;
    assign next_ctrl.rx_nine = rx_nine;

    // Register writes keep only writable bits
    wire [7:0] next_xmt = wr_xmt ? (wbyte & `SPCS_TX_WRITE_MASK) : xmt_ctrl;
    wire [7:0] rcv_written = wr_rcv ? (wbyte & `SPCS_RX_WRITE_MASK) : rcv_ctrl;
    wire [7:0] single_receive_enable_clr = single_done & ~wr_rcv ? (8'h01 << `SPCS_RX_SINGLE) : 8'h00;
    wire [7:0] next_rcv = rcv_written & ~single_receive_enable_clr;

    // Flags
    wire next_overrun = overrun_evt | (overrun_error_flag & cont_rx);
    wire next_full = load_word | (buffer_full & ~rd_rdata);
    wire tx_empty_evt = shifter_empty & ~shifter_empty_prev;

    // Interrupt status, set wins over write-one clear
    wire [`SPCS_INT_W-1:0] int_events;
    assign int_events[`SPCS_INT_RX_WORD] = load_word;
    assign int_events[`SPCS_INT_FRAMING] = load_word & rx_word.framing_error;
    assign int_events[`SPCS_INT_OVERRUN] = overrun_evt;
    assign int_events[`SPCS_INT_TX_EMPTY] = tx_empty_evt;
    wire [`SPCS_INT_W-1:0] int_clr = (bus_wr & sel_stat) ? wbyte[`SPCS_INT_W-1:0] : '0;
    wire [`SPCS_INT_W-1:0] next_status = (int_status & ~int_clr) | int_events;
    wire [`SPCS_INT_W-1:0] next_mask = (bus_wr & sel_mask) ? wbyte[`SPCS_INT_W-1:0] : int_mask;

    // Read views
    wire [7:0] xmt_view = xmt_ctrl
        | ({7'h00, shifter_empty} << `SPCS_TX_SHIFTER_EMPTY);
    wire [7:0] rcv_view = rcv_ctrl
        | ({7'h00, framing_error_flag} << `SPCS_RX_FRAMING)
        | ({7'h00, overrun_error_flag} << `SPCS_RX_OVERRUN)
        | ({7'h00, receive_ninth_bit} << `SPCS_RX_NINTH);
    wire [7:0] rd_value = sel_xmt ? xmt_view :
                          sel_rcv ? rcv_view :
                          sel_rdata ? receive_data_register :
                          sel_stat ? {{(8-`SPCS_INT_W){1'b0}}, int_status} :
                          sel_mask ? {{(8-`SPCS_INT_W){1'b0}}, int_mask} : 8'h00;

    // Bus answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? {{(DATA_W-8){1'b0}}, rd_value} : '0;
        end
    end

    // Control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xmt_ctrl <= `SPCS_TX_RESET;
            rcv_ctrl <= `SPCS_RX_RESET;
            ctrl <= '0;
            pins_owned <= 1'b0;
        end else begin
            xmt_ctrl <= next_xmt;
            rcv_ctrl <= next_rcv;
            ctrl <= next_ctrl;
            pins_owned <= owned_now;
        end
    end

    // Status flags and receive buffer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shifter_empty <= 1'b1;
            shifter_empty_prev <= 1'b1;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
            receive_ninth_bit <= 1'b0;
            buffer_full <= 1'b0;
            receive_data_register <= 8'h00;
        end else begin
            shifter_empty <= tx_shifter_empty;
            shifter_empty_prev <= shifter_empty;
            overrun_error_flag <= next_overrun;
            buffer_full <= next_full;
            if (load_word) begin
                framing_error_flag <= rx_word.framing_error;
                receive_ninth_bit <= rx_word.ninth;
                receive_data_register <= rx_word.data;
            end
        end
    end

    // Interrupts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_status <= `SPCS_INT_RESET;
            int_mask <= `SPCS_INT_RESET;
            irq <= 1'b0;
        end else begin
            int_status <= next_status;
            int_mask <= next_mask;
            irq <= |(next_status & next_mask);
        end
    end

    // Pin input synchronisers, a change counts once stages two and three agree
    wire [`SPCS_PIN_COUNT-1:0] pin_raw = {receive_data_pin_in, transmit_clock_pin_in};
    wire [`SPCS_PIN_COUNT-1:0] pin_clean;

    genvar gi;
    generate
        for (gi = 0; gi < `SPCS_PIN_COUNT; gi++) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic held;
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    held <= 1'b1;
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        held <= s3;
                    end
                end
            end
            assign pin_clean[gi] = held;
        end
    endgenerate

    assign clock_pin_sync = pin_clean[`SPCS_PIN_CLOCK];
    assign data_pin_sync = pin_clean[`SPCS_PIN_DATA];

    // Pin drive only while the port owns the pins
    assign transmit_clock_pin_out = dp_clock_drive.out;
    assign transmit_clock_pin_oe = dp_clock_drive.oe & pins_owned;
    assign receive_data_pin_out = dp_data_drive.out;
    assign receive_data_pin_oe = dp_data_drive.oe & pins_owned;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_bus_ack_once: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    a_pin_gating: assert property (!pins_owned |-> !transmit_clock_pin_oe && !receive_data_pin_oe)
        else $error("pin driven while not owned");
    a_master_sync: assert property (wr_xmt && !wbyte[`SPCS_TX_LINK_MODE] |=> ##1 !ctrl.master)
        else $error("master outside synchronous mode");
    a_tx_override: assert property (ctrl.sync_mode && ctrl.rx_enable |-> !ctrl.tx_enable)
        else $error("transmit not overridden by receive");
    a_speed_async: assert property (ctrl.sync_mode |-> !ctrl.speed_high)
        else $error("speed select active in synchronous mode");
    a_empty_read: assert property (bus_rd && sel_xmt |=>
        wb_dat_o[`SPCS_TX_SHIFTER_EMPTY] == $past(shifter_empty))
        else $error("shifter empty bit misread");
    a_single_clear: assert property (single_done && !wr_rcv |=> !rcv_ctrl[`SPCS_RX_SINGLE])
        else $error("single receive not cleared");
    a_addr_filter: assert property (word_in && filter_on && !rx_word.ninth |-> !load_word
        ##1 !int_status[`SPCS_INT_RX_WORD] || $past(int_status[`SPCS_INT_RX_WORD]))
        else $error("data word passed address filter");
    a_overrun_clear: assert property (!cont_rx && !overrun_evt |=> !overrun_error_flag)
        else $error("overrun flag survives continuous clear");
    a_framing_hold: assert property (!load_word |=> $stable(framing_error_flag))
        else $error("framing flag changed without a word");
    a_ro_bits: assert property (wr_rcv |=> rcv_ctrl[`SPCS_RX_FRAMING:0] == 3'b000)
        else $error("read-only bits took a write");

    c_overrun: cover property (overrun_evt);
    c_single_done: cover property (single_done ##1 !rcv_ctrl[`SPCS_RX_SINGLE]);
    c_addr_drop: cover property (word_in && filter_on && !rx_word.ninth);
    c_irq: cover property (!irq ##1 irq);

endmodule

// ==== verification/spcs_peer_model.sv ====
// Behavioural serial data path standing beside the control block
module spcs_peer_model
    import spcs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Controls from the block
    input wire spcs_ctrl_type ctrl,
    // Data path outputs
    output spcs_rx_word_type rx_word,
    output logic tx_shifter_empty,
    output spcs_drive_type dp_clock_drive,
    output spcs_drive_type dp_data_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        rx_word = '0;
        tx_shifter_empty = 1'b1;
    end

    // Clock pin driven low only as synchronous master
    assign dp_clock_drive = '{out: 1'b0, oe: ctrl.sync_mode & ctrl.master};
    assign dp_data_drive = '{out: ctrl.tx_ninth_bit, oe: ctrl.tx_enable};

    // One word pulse, then stale fields inverted
    task automatic send(input logic [7:0] d, input logic n, input logic fe);
        rx_word <= '{1'b1, d, n, fe};
        @(posedge clk_sys);
        rx_word <= '{1'b0, ~d, ~n, ~fe};
    endtask

    task automatic set_empty(input logic v);
        tx_shifter_empty <= v;
    endtask
endmodule

// ==== verification/spcs_top_tb.sv ====
// Self-checking bench for the serial port control block
module spcs_top_tb
    import spcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq, pins_owned, clock_pin_sync, data_pin_sync;
    logic [1:0] port_direction_bits = 2'b11;
    spcs_rx_word_type rx_word;
    logic tx_shifter_empty;
    spcs_drive_type dp_clock_drive, dp_data_drive;
    spcs_ctrl_type ctrl;
    logic [7:0] receive_data_register, q;
    logic ck_out, ck_oe, dt_out, dt_oe;
    logic [7:0] txc [5] = '{8'h65, 8'hFF, 8'hB0, 8'h3F, 8'h00};
    logic [7:0] rxc [5] = '{8'h80, 8'hD7, 8'hA0, 8'h80, 8'h30};
    // Pins pulled up while nobody drives them
    wire logic ck_pin = ck_oe ? ck_out : 1'b1;
    wire logic dt_pin = dt_oe ? dt_out : 1'b1;
    int err_count = 0;
    int samples_checked = 0;

    always #25 clk_sys = ~clk_sys;

    spcs_top spcs_top_inst (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .irq, .port_direction_bits, .rx_word,
        .tx_shifter_empty, .dp_clock_drive, .dp_data_drive, .ctrl, .clock_pin_sync,
        .data_pin_sync, .receive_data_register, .pins_owned, .transmit_clock_pin_in(ck_pin),
        .transmit_clock_pin_out(ck_out), .transmit_clock_pin_oe(ck_oe),
        .receive_data_pin_in(dt_pin), .receive_data_pin_out(dt_out),
        .receive_data_pin_oe(dt_oe));

    spcs_peer_model spcs_peer_model_inst (.clk_sys, .ctrl, .rx_word, .tx_shifter_empty,
        .dp_clock_drive, .dp_data_drive);

    function automatic logic [9:0] exp_ctrl(input logic [7:0] t, input logic [7:0] r);
        logic s;
        s = t[4];
        return {r[7], s, t[7] & s, t[2] & ~s, t[5] & ~(s & (r[5] | r[4])), t[6], t[0],
            r[7] & (r[4] | (r[5] & s & t[7])), r[5] & s & t[7] & ~r[4], r[6]};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One classic cycle, released after ack and followed by an idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", wb_ack_o, 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        wb(1'b0, a, 8'h00);
        chk(name, q, exp);
    endtask

    task automatic rx(input logic [7:0] d, input logic n, input logic fe);
        spcs_peer_model_inst.send(d, n, fe);
        tick(2);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        tick(3000);
        err_count++;
        final_report;
    end

    initial begin
        tick(4);
        reset_n <= 1'b1;
        tick(4);
        rd(8'h98, 8'h02, "tx reset");
        rd(8'h18, 8'h00, "rx reset");
        rd(8'h40, 8'h00, "unmapped");
        wr(8'h20, 8'h0F);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h98, txc[i]);
            wr(8'h18, rxc[i]);
            tick(2);
            chk("ctrl", ctrl, exp_ctrl(txc[i], rxc[i]));
            rd(8'h98, (txc[i] & 8'hF5) | 8'h02, "tx ctrl");
            rd(8'h18, rxc[i] & 8'hF8, "rx ctrl");
        end
        $display("test modes done");
        wr(8'h98, 8'hB0);
        for (int i = 0; i < 3; i++) begin
            port_direction_bits <= (i == 1) ? 2'b10 : 2'b11;
            wr(8'h18, (i == 2) ? 8'h00 : 8'h80);
            tick(6);
            chk("owned", pins_owned, i == 0);
            chk("clock oe", ck_oe, i == 0);
            chk("clock sync", clock_pin_sync, i != 0);
            chk("data oe", dt_oe, i == 0);
            chk("data sync", data_pin_sync, i != 0);
        end
        $display("test pins done");
        wr(8'h18, 8'h90);
        wr(8'h98, 8'h00);
        wr(8'h20, 8'h0F);
        rx(8'h5A, 1'b1, 1'b0);
        chk("data", receive_data_register, 8'h5A);
        chk("irq masked", irq, 1'b0);
        rd(8'h18, 8'h91, "ninth");
        rd(8'h20, 8'h01, "status");
        wr(8'h24, 8'h01);
        tick(2);
        chk("irq", irq, 1'b1);
        rd(8'h1C, 8'h5A, "rx data");
        rx(8'hA5, 1'b0, 1'b1);
        rd(8'h18, 8'h94, "framing");
        rx(8'h3C, 1'b0, 1'b0);
        chk("kept", receive_data_register, 8'hA5);
        rd(8'h18, 8'h96, "overrun");
        wr(8'h18, 8'h80);
        tick(2);
        rd(8'h18, 8'h84, "overrun clear");
        wr(8'h20, 8'h0F);
        tick(2);
        chk("irq clear", irq, 1'b0);
        rd(8'h1C, 8'hA5, "rx data");
        $display("test receive done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h98, (i == 3) ? 8'h90 : 8'h00);
            wr(8'h18, (i == 2) ? 8'h98 : 8'hD8);
            rx(8'h11 * (i + 1), i == 1, 1'b0);
            chk("addr", receive_data_register, (i == 0) ? 8'hA5 : 8'h11 * (i + 1));
            wb(1'b0, 8'h1C, 8'h00);
        end
        wr(8'h18, 8'hA0);
        rx(8'h55, 1'b0, 1'b0);
        chk("single data", receive_data_register, 8'h55);
        chk("single", ctrl.rx_single, 1'b0);
        rd(8'h18, 8'h80, "single clear");
        $display("test address done");
        wr(8'h20, 8'h0F);
        spcs_peer_model_inst.set_empty(1'b0);
        tick(3);
        rd(8'h98, 8'h90, "shifter full");
        spcs_peer_model_inst.set_empty(1'b1);
        tick(3);
        rd(8'h98, 8'h92, "shifter empty");
        rd(8'h20, 8'h08, "empty event");
        wr(8'h24, 8'h08);
        tick(2);
        chk("irq empty", irq, 1'b1);
        $display("test shifter done");
        final_report;
    end
endmodule
